// ---- design/adc_port_map.svh ----
`ifndef ADC_PORT_MAP_SVH
`define ADC_PORT_MAP_SVH

// Result and configuration widths
`define RESULT_W 14
`define CFG_W 8
`define CH_IDX_W 3

// Channel-enable register: bit n enables channel n, all set at power-up
`define CFG_RESET 8'hFF
`define CFG_CH0_POS 0

// Conversion clock timing, in conversion clock cycles
`define FIRST_RESULT_CYC 5'h11
`define RESULT_SPACING_CYC 5'h03

// Clock rates in kHz
`define SYS_CLK_KHZ 25000
`define INT_OSC_KHZ 10000

`endif

// ---- design/adc_port_pkg.sv ----
package adc_port_pkg;

  typedef enum logic [1:0]
  {
    ST_TRACK = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b10
  } seq_state_t;

  typedef logic [13:0] result_word_t;

endpackage

// ---- design/result_fifo.sv ----
`timescale 1ns/1ns
`default_nettype none

module result_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  // System
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
      $error("result_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] rptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;
  logic [AW-1:0] nxt_rptr;
  logic [WIDTH-1:0] out_data_ff;

  assign in_ready = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign nxt_rptr = pop ? rptr_ff + 1'b1 : rptr_ff;
  assign out_data = out_data_ff;

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_ff[wptr_ff] <= in_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || flush)
    begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (push)
        wptr_ff <= wptr_ff + 1'b1;
      rptr_ff <= nxt_rptr;
      count_ff <= count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // Head register; a word written into the new head slot bypasses the array
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      out_data_ff <= '0;
    else if (push && nxt_rptr == wptr_ff)
      out_data_ff <= in_data;
    else
      out_data_ff <= mem_ff[nxt_rptr];
  end

  fifo_no_overrun_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !in_ready |=> count_ff == DEPTH[AW:0] || $past(pop) || $past(flush))
    else $error("fifo count changed while full without a pop");

endmodule

`default_nettype wire

// ---- design/simultaneous_adc_host_port.sv ----
`timescale 1ns/1ns
`default_nettype none

`include "adc_port_map.svh"

// Functional notes
// (R1) Internal conversion clock nominally 10 MHz
// (R2) Select high internal, low external clock
// (R3) External clock at most 15 MHz, 30-70% duty; edge detection on the 25 MHz system clock sees it only below 12.5 MHz
// (R4) Internal conversion time grows with channel count
// (R5) 14-bit results; low eight lines bidirectional
// (R6) Data lines float when read or select high
// (R7) Enable bit n controls channel n
// (R8) Enable bits above implemented channels ignored
// (R9) Enable byte captured on write strobe rise
// (R10) New enables apply from next convert start
// (R11) Shutdown keeps channel enables unchanged
// (R12) Host writes enables before first conversion
// (R13) Track while start low, sample on rise
// (R14) Per-result pulse; final strobe on last result
// (R15) External clock starts within 10 us, >=100 kHz
// (R16) First result at 17th clock, then every third
// (R17) Host holds start high until last read
// (R18) Sequence takes 16+3(N-1)+1 clocks plus quiet
// (R19) Host keeps bus idle before start rises
// (R20) Read low drives result, high releases bus
// (R21) Host waits for each result strobe edge
// (R22) Power-up enables every channel
// (R23) Each read pulse gives the next result
// (R24) Results ascend by channel, disabled skipped
// (R25) Result pulse one clock; final low till restart
module simultaneous_adc_host_port
  import adc_port_pkg::*;
#(
  parameter int NUM_CH = 8,
  parameter int FIFO_DEPTH = 8
) (
  // System
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Host bus pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [`CFG_W-1:0] data_lo_in,
  output logic [`RESULT_W-1:0] data_out,
  output logic data_oe,
  // Conversion control pins
  input wire logic sample_hold_ctrl,
  input wire logic ext_clk,
  input wire logic clock_source_sel,
  input wire logic power_down_in,
  input wire logic power_all_inputs,
  // Status strobes
  output logic result_ready_n,
  output logic final_result_n,
  // Converter core
  output logic sample_hold,
  output logic [`CH_IDX_W-1:0] conv_ch,
  input wire logic [`RESULT_W-1:0] conv_result,
  output logic [`CFG_W-1:0] channel_power
);

  generate
    if (NUM_CH != 2 && NUM_CH != 4 && NUM_CH != 8)
    begin : g_bad_ch
      $error("NUM_CH must be 2, 4 or 8");
    end
  endgenerate

  localparam logic [`CFG_W-1:0] IMPL_MASK = `CFG_W'((1 << NUM_CH) - 1);

  function automatic logic [`CH_IDX_W-1:0] lowest_ch(input logic [`CFG_W-1:0] m);
    logic [`CH_IDX_W-1:0] idx;
    idx = '0;
    for (int i = `CFG_W - 1; i >= 0; i--)
    begin
      if (m[i])
        idx = `CH_IDX_W'(i);
    end
    return idx;
  endfunction

  // Pin synchronisers
  localparam int SYNC_W = 16;
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;

  assign pins_raw = {data_lo_in, power_all_inputs, power_down_in, clock_source_sel,
                     ext_clk, sample_hold_ctrl, wr_n, rd_n, cs_n};

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      // Idle pin levels, so no false start edge follows reset
      sync1_ff <= 16'h000F;
      sync2_ff <= 16'h000F;
    end
    else
    begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
    end
  end

  logic cs_s;
  logic rd_s;
  logic wr_s;
  logic cv_s;
  logic ext_s;
  logic sel_s;
  logic pd_s;
  logic all_s;
  logic [`CFG_W-1:0] din_s;

  assign {din_s, all_s, pd_s, sel_s, ext_s, cv_s, wr_s, rd_s, cs_s} = sync2_ff;

  // Previous samples for edge detection
  logic cs_prev_ff;
  logic rd_prev_ff;
  logic wr_prev_ff;
  logic cv_prev_ff;
  logic ext_prev_ff;
  logic [`CFG_W-1:0] din_prev_ff;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cs_prev_ff <= 1'b1;
      rd_prev_ff <= 1'b1;
      wr_prev_ff <= 1'b1;
      cv_prev_ff <= 1'b1;
      ext_prev_ff <= 1'b0;
      din_prev_ff <= '0;
    end
    else
    begin
      cs_prev_ff <= cs_s;
      rd_prev_ff <= rd_s;
      wr_prev_ff <= wr_s;
      cv_prev_ff <= cv_s;
      ext_prev_ff <= ext_s;
      din_prev_ff <= din_s;
    end
  end

  logic cfg_write;
  logic rd_fall;
  logic cv_rise;
  logic cv_fall;

  // Select must already be low while write was low
  assign cfg_write = wr_s && !wr_prev_ff && !cs_prev_ff; // R9
  assign rd_fall = !rd_s && rd_prev_ff && !cs_s; // R23
  assign cv_rise = cv_s && !cv_prev_ff;
  assign cv_fall = !cv_s && cv_prev_ff;

  // Internal oscillator: fractional accumulator gives a 10 MHz average rate
  localparam logic [15:0] OSC_STEP = 16'(`INT_OSC_KHZ);
  localparam logic [15:0] OSC_WRAP = 16'(`SYS_CLK_KHZ);
  logic [15:0] osc_acc_ff;
  logic [15:0] nxt_osc_acc;
  logic osc_tick_ff;

  assign nxt_osc_acc = osc_acc_ff + OSC_STEP;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      osc_acc_ff <= '0;
      osc_tick_ff <= 1'b0;
    end
    else if (nxt_osc_acc >= OSC_WRAP)
    begin
      osc_acc_ff <= nxt_osc_acc - OSC_WRAP; // R1 R4
      osc_tick_ff <= 1'b1;
    end
    else
    begin
      osc_acc_ff <= nxt_osc_acc;
      osc_tick_ff <= 1'b0;
    end
  end

  // External clock must stay well below half the system rate to be seen
  logic ext_tick;
  logic conv_tick;

  assign ext_tick = ext_s && !ext_prev_ff;
  assign conv_tick = sel_s ? osc_tick_ff : ext_tick; // R2

  // Channel-enable register
  logic [`CFG_W-1:0] cfg_ff;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      cfg_ff <= `CFG_RESET; // R22
    else if (cfg_write)
      cfg_ff <= din_prev_ff; // R9 R11
  end

  // Sequencer
  seq_state_t state_ff;
  logic [`CFG_W-1:0] active_ff;
  logic [`CFG_W-1:0] rem_ff;
  logic [4:0] wait_ff;
  logic [`CH_IDX_W-1:0] conv_ch_ff;
  logic result_n_ff;
  logic final_n_ff;
  logic fifo_in_ready;
  logic emit;
  logic [`CFG_W-1:0] nxt_rem;

  assign emit = (state_ff == ST_CONV) && conv_tick && (wait_ff == 5'h01) && fifo_in_ready;
  assign nxt_rem = rem_ff & ~(`CFG_W'(1) << conv_ch_ff);

  // Enables apply from the falling start edge that opens the next sample
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      active_ff <= `CFG_RESET & IMPL_MASK;
    else if (cv_fall)
      active_ff <= cfg_ff & IMPL_MASK; // R8 R10
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || pd_s || cv_fall)
    begin
      state_ff <= ST_TRACK;
      rem_ff <= '0;
      wait_ff <= '0;
    end
    else
    begin
      unique case (state_ff)
        ST_TRACK:
        begin
          if (cv_rise)
          begin
            state_ff <= (active_ff == '0) ? ST_DONE : ST_CONV; // R13
            rem_ff <= active_ff;
            wait_ff <= `FIRST_RESULT_CYC; // R16
          end
        end
        ST_CONV:
        begin
          if (emit)
          begin
            rem_ff <= nxt_rem; // R24
            wait_ff <= `RESULT_SPACING_CYC; // R16 R18
            if (nxt_rem == '0)
              state_ff <= ST_DONE;
          end
          else if (conv_tick && wait_ff != 5'h01)
            wait_ff <= wait_ff - 5'h01;
        end
        ST_DONE:
        begin
          state_ff <= ST_DONE;
        end
        default:
        begin
          state_ff <= ST_TRACK;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      conv_ch_ff <= '0;
    else if (state_ff == ST_TRACK && cv_rise)
      conv_ch_ff <= lowest_ch(active_ff); // R24
    else if (emit)
      conv_ch_ff <= lowest_ch(nxt_rem);
  end

  // Strobes
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || pd_s)
      result_n_ff <= 1'b1;
    else if (emit)
      result_n_ff <= 1'b0; // R14
    else if (conv_tick || cv_fall)
      result_n_ff <= 1'b1; // R25
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || cv_fall)
      final_n_ff <= 1'b1; // R25
    else if ((emit && nxt_rem == '0) || (state_ff == ST_TRACK && cv_rise && active_ff == '0))
      final_n_ff <= 1'b0; // R14
  end

  // Result buffer; a full buffer stalls the sequencer rather than dropping
  logic fifo_out_valid;
  logic [`RESULT_W-1:0] fifo_head;
  logic [`RESULT_W-1:0] dout_ff;

  result_fifo #(
    .WIDTH(`RESULT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_result_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .flush(cv_fall),
    .in_valid(emit),
    .in_ready(fifo_in_ready),
    .in_data(conv_result), // R5
    .out_valid(fifo_out_valid),
    .out_ready(rd_fall),
    .out_data(fifo_head)
  );

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      dout_ff <= '0;
    else if (rd_fall && fifo_out_valid)
      dout_ff <= fifo_head; // R20 R23
  end

  // Per-channel power: shutdown wins, then all-on, then the enable bit
  genvar gi;
  generate
    for (gi = 0; gi < `CFG_W; gi++)
    begin : g_power
      assign channel_power[gi] = !pd_s && IMPL_MASK[gi] && (all_s || cfg_ff[gi]); // R7 R8
    end
  endgenerate

  assign data_oe = !rd_s && !cs_s; // R6 R20
  assign data_out = dout_ff; // R5
  assign result_ready_n = result_n_ff;
  assign final_result_n = final_n_ff;
  assign sample_hold = (state_ff != ST_TRACK); // R13
  assign conv_ch = conv_ch_ff;

  // Helper for first-result timing
  logic [6:0] ticks_ff;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || state_ff == ST_TRACK)
      ticks_ff <= '0;
    else if (conv_tick && ticks_ff != 7'h7F)
      ticks_ff <= ticks_ff + 7'h01;
  end

  sequence cfg_wr_s;
    wr_s && !wr_prev_ff && !cs_prev_ff;
  endsequence

  sequence start_s;
    state_ff == ST_TRACK && cv_rise && !pd_s;
  endsequence

  cfg_reset_a: assert property (@(posedge sys_clk) sys_rst |=> cfg_ff == 8'hFF) // R22
    else $error("enable register not all ones after reset");

  bus_float_a: assert property (@(posedge sys_clk) disable iff (sys_rst) (rd_s || cs_s) |-> !data_oe) // R6
    else $error("data driven while read or select high");

  cfg_capture_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cfg_wr_s |=> cfg_ff == $past(din_prev_ff)) // R9
    else $error("enable byte not captured on write rise");

  cfg_shutdown_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (pd_s && !cfg_write) |=> $stable(cfg_ff)) // R11
    else $error("enable register changed in shutdown");

  mask_deferred_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!cv_fall && cfg_write) |=> $stable(active_ff)) // R10
    else $error("new enables used before next start");

  impl_mask_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (active_ff & ~IMPL_MASK) == '0 && (channel_power & ~IMPL_MASK) == '0) // R8
    else $error("unimplemented channel enabled");

  start_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    start_s |=> sample_hold && wait_ff == 5'h11 && rem_ff == $past(active_ff)) // R13
    else $error("conversion did not start on start rise");

  first_result_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (emit && rem_ff == active_ff) |-> ticks_ff == 7'h10) // R16
    else $error("first result not on 17th clock");

  result_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst || pd_s)
    (!result_ready_n && conv_tick && !emit) |=> result_ready_n) // R25
    else $error("result strobe longer than one clock");

  order_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    emit |-> rem_ff[conv_ch_ff] && (rem_ff & ((`CFG_W'(1) << conv_ch_ff) - 1'b1)) == '0) // R24
    else $error("results out of channel order");

  final_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!final_result_n && !cv_fall) |=> !final_result_n) // R25
    else $error("final strobe released early");

  read_next_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (rd_fall && fifo_out_valid) |=> data_out == $past(fifo_head)) // R23
    else $error("read did not present next result");

endmodule

`default_nettype wire

// ---- tb/host_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module host_model (
  // System
  input wire logic sys_clk,
  // Bus pins
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] host_data,
  output logic sample_hold_ctrl,
  // Device side
  input wire logic [13:0] data_out,
  input wire logic data_oe
);
  initial
  begin
    cs_n = 1'h1;
    rd_n = 1'h1;
    wr_n = 1'h1;
    host_data = 8'h00;
    sample_hold_ctrl = 1'h1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  task automatic write_cfg(input logic sel_n, input logic [7:0] val);
    tick(1);
    cs_n = sel_n;
    wr_n = 1'h0;
    host_data = val;
    tick(4);
    wr_n = 1'h1;
    tick(4);
    cs_n = 1'h1;
    // Released lines must not look like the old byte
    host_data = ~val;
  endtask

  task automatic read_word(output logic [13:0] w, output logic oe);
    tick(1);
    cs_n = 1'h0;
    rd_n = 1'h0;
    tick(5);
    w = data_out;
    oe = data_oe;
    rd_n = 1'h1;
    cs_n = 1'h1;
    tick(4);
  endtask

  task automatic start_low();
    tick(1);
    sample_hold_ctrl = 1'h0;
  endtask

  task automatic start_high();
    tick(6);
    // Caller keeps it high until the last result is read
    sample_hold_ctrl = 1'h1;
  endtask
endmodule

`default_nettype wire

// ---- tb/test_simultaneous_adc_host_port.sv ----
`timescale 1ns/1ns
`default_nettype none

module test_simultaneous_adc_host_port;
  logic sys_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic [7:0] host_data;
  logic [7:0] data_lo_in;
  logic [13:0] data_out;
  logic data_oe;
  logic sample_hold_ctrl;
  logic ext_clk = 1'h0;
  logic ext_run = 1'h0;
  logic clock_source_sel;
  logic power_down_in;
  logic power_all_inputs;
  logic result_ready_n;
  logic final_result_n;
  logic sample_hold;
  logic [2:0] conv_ch;
  logic [13:0] conv_result;
  logic [7:0] channel_power;
  logic [13:0] status;
  logic [13:0] w;
  logic oe;
  int bad_count = 0;
  int cmp_count = 0;
  int pulse_cnt = 0;
  int ext_cnt = 0;
  int n;

  always #20 sys_clk = ~sys_clk;
  // Far clock stands low outside a conversion frame
  always #250 ext_clk = ext_run ? ~ext_clk : 1'h0;
  always @(posedge ext_clk) ext_cnt++;
  always @(negedge result_ready_n) pulse_cnt++;
  assign data_lo_in = data_oe ? data_out[7:0] : host_data;
  // Core model tags each result with its channel
  assign conv_result = {11'h2A5, conv_ch};
  assign status = {final_result_n, result_ready_n, data_oe, sample_hold, 2'h0, channel_power};

  simultaneous_adc_host_port i_simultaneous_adc_host_port (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .cs_n(cs_n),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .data_lo_in(data_lo_in),
    .data_out(data_out),
    .data_oe(data_oe),
    .sample_hold_ctrl(sample_hold_ctrl),
    .ext_clk(ext_clk),
    .clock_source_sel(clock_source_sel),
    .power_down_in(power_down_in),
    .power_all_inputs(power_all_inputs),
    .result_ready_n(result_ready_n),
    .final_result_n(final_result_n),
    .sample_hold(sample_hold),
    .conv_ch(conv_ch),
    .conv_result(conv_result),
    .channel_power(channel_power)
  );

  host_model i_host_model (
    .sys_clk(sys_clk),
    .cs_n(cs_n),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .host_data(host_data),
    .sample_hold_ctrl(sample_hold_ctrl),
    .data_out(data_out),
    .data_oe(data_oe)
  );

  task automatic chk(input string nm, input logic [13:0] exp, input logic [13:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out();
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wait_for(input logic fin, input logic val, input int lim, output int cnt);
    cnt = 0;
    while ((fin ? final_result_n : result_ready_n) !== val && cnt < lim)
    begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end
  endtask

  task automatic run_start();
    i_host_model.start_low();
    i_host_model.tick(4);
    chk("track_status", 14'h3000, status & 14'h3C00);
    i_host_model.start_high();
    pulse_cnt = 0;
    ext_cnt = 0;
  endtask

  task automatic read_seq(input logic [7:0] mask);
    logic [13:0] last;
    last = 14'h0000;
    for (int ch = 0; ch < 8; ch++)
    begin
      if (mask[ch])
      begin
        i_host_model.read_word(w, oe);
        last = {11'h2A5, 3'(ch)};
        chk("result", last, w);
        chk("drive_on", 14'h0001, {13'h0000, oe});
      end
    end
    // One read too many: FIFO empty, word must not change
    i_host_model.read_word(w, oe);
    chk("empty_read", last, w);
    chk("drive_off", 14'h0000, {13'h0000, data_oe});
  endtask

  initial
  begin
    #800000;
    bad_count++;
    close_out();
  end

  initial
  begin
    clock_source_sel = 1'h1;
    power_down_in = 1'h0;
    power_all_inputs = 1'h0;
    i_host_model.tick(3);
    sys_rst = 1'h0;
    i_host_model.tick(2);
    chk("reset_status", 14'h30FF, status);
    i_host_model.write_cfg(1'h0, 8'hFF);
    run_start();
    wait_for(1'h0, 1'h0, 200, n);
    chk("first_latency", 14'h0001, {13'h0000, n >= 40 && n <= 50});
    wait_for(1'h0, 1'h1, 10, n);
    chk("strobe_width", 14'h0001, {13'h0000, n >= 2 && n <= 3});
    // Write lands mid-sequence; this run must still yield all eight
    i_host_model.write_cfg(1'h0, 8'h05);
    wait_for(1'h1, 1'h0, 200, n);
    chk("pulses_all", 14'h0008, 14'(pulse_cnt));
    read_seq(8'hFF);
    chk("final_held", 14'h1405, status);
    chk("power_sel", 14'h0005, {6'h00, channel_power});
    i_host_model.write_cfg(1'h1, 8'h00);
    chk("power_cs_high", 14'h0005, {6'h00, channel_power});
    power_down_in = 1'h1;
    i_host_model.tick(4);
    chk("power_down", 14'h0000, {6'h00, channel_power});
    power_down_in = 1'h0;
    i_host_model.tick(4);
    chk("power_back", 14'h0005, {6'h00, channel_power});
    power_all_inputs = 1'h1;
    i_host_model.tick(4);
    chk("power_all", 14'h00FF, {6'h00, channel_power});
    power_all_inputs = 1'h0;
    clock_source_sel = 1'h0;
    run_start();
    // Far clock starts once the sequencer has left tracking
    i_host_model.tick(4);
    ext_run = 1'h1;
    wait_for(1'h0, 1'h0, 1000, n);
    chk("ext_first", 14'h0011, 14'(ext_cnt));
    wait_for(1'h0, 1'h1, 100, n);
    wait_for(1'h0, 1'h0, 200, n);
    chk("ext_second", 14'h0014, 14'(ext_cnt));
    wait_for(1'h1, 1'h0, 200, n);
    chk("ext_pulses", 14'h0002, 14'(pulse_cnt));
    ext_run = 1'h0;
    read_seq(8'h05);
    clock_source_sel = 1'h1;
    i_host_model.write_cfg(1'h0, 8'h00);
    run_start();
    wait_for(1'h1, 1'h0, 50, n);
    chk("empty_mask", 14'h0001, {13'h0000, final_result_n === 1'h0 && pulse_cnt == 0});
    close_out();
  end
endmodule

`default_nettype wire
